// >>> rtl/clk_divider.sv
// Enabled divide-by-2N toggle generator with a terminal-count pulse
`timescale 1ns/1ps
`default_nettype none

module clk_divider (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       count_en,
  input  wire logic [clkgen_pkg::CNT_W-1:0] half_count,
  output logic                            tick,
  output logic                            clk_out
);
  import clkgen_pkg::*;

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             clk_out_r;
  logic             clk_out_nxt;

  // Terminal count: one enable pulse per half period
  assign tick    = count_en && (count_r == '0);
  assign clk_out = clk_out_r;

  // Reload on terminal count and toggle the output for near 50% duty
  always_comb begin
    count_nxt   = count_r;
    clk_out_nxt = clk_out_r;
    if (tick) begin
      count_nxt   = (half_count == '0) ? '0 : half_count - CNT_W'(1);
      clk_out_nxt = ~clk_out_r;
    end else if (count_en) begin
      count_nxt = count_r - CNT_W'(1);
    end
  end

  // Known phase after reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_r   <= '0;
      clk_out_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      clk_out_r <= clk_out_nxt;
    end
  end

endmodule : clk_divider

`default_nettype wire

// >>> rtl/clkgen_pkg.sv
// Constants and mode types for the switch port clock generator
package clkgen_pkg;

  // Reference clock period and the derived cycle counts
  localparam int unsigned MCLK_PERIOD_NS = 20;
  localparam int unsigned USEC_NS        = 1000;
  localparam int unsigned USEC_CYCLES    = USEC_NS / MCLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 16;

  // Reset value of the microsecond divider setting (cycles per microsecond)
  localparam logic [CNT_W-1:0] USEC_DIV_RST = CNT_W'(USEC_CYCLES);

  // Half periods of the derived clocks
  localparam logic [CNT_W-1:0] MDC_HALF_US  = 16'h0001;  // 2 us period
  localparam logic [CNT_W-1:0] SCL_HALF_US  = 16'h000a;  // 20 us period
  localparam logic [CNT_W-1:0] RMII100_HALF = 16'h0001;  // Reference / 2
  localparam logic [CNT_W-1:0] RMII10_HALF  = 16'h000a;  // Reference / 20
  localparam logic [CNT_W-1:0] GPSI_HALF    = 16'h0001;  // Reference / 2
  localparam logic [CNT_W-1:0] GIG_RX_HALF  = 16'h0001;  // Reference / 2

  // Fast port interface modes
  typedef enum logic [2:0] {
    FAST_NORMAL   = 3'b001,
    FAST_REV_MII  = 3'b010,
    FAST_REV_GPSI = 3'b100
  } fast_mode_t;

  // Gigabit port interface modes
  typedef enum logic [2:0] {
    GIG_OTHER   = 3'b001,
    GIG_GMII    = 3'b010,
    GIG_REV_MII = 3'b100
  } gig_mode_t;

endpackage : clkgen_pkg

// >>> rtl/switch_port_clock_generation.sv
// Clock generation for the switch fast ports, gigabit port and management pins
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Build a one microsecond tick from the reference, using the programmable divider setting.
// - Management clock is the fast reference divided by one hundred.
// - Two-wire serial clock is the fast reference divided by one thousand.
// - Off-nominal reference rescales management and serial clocks through the divider setting.
// - Reverse MII fast port clocks are reference over two or over twenty.
// - Reverse GPSI fast port clocks are reference over two from a 50 MHz reference.
// - In GMII mode the gigabit transmit clock equals the gigabit reference.
// - Gigabit reverse MII receive clock is reference over two, 100 Mbps only.
module switch_port_clock_generation (
  input  wire logic                         mclk,
  input  wire logic                         sys_rst,
  input  wire logic [clkgen_pkg::CNT_W-1:0] microsecond_divider,
  input  wire clkgen_pkg::fast_mode_t       fast_port_mode,
  input  wire logic                         fast_port_speed_100,
  input  wire clkgen_pkg::gig_mode_t        gig_port_mode,
  input  wire logic                         gig_ref_clk,
  output logic                              usec_tick,
  output logic                              mdc,
  output logic                              scl,
  output logic                              fast_tx_clk,
  output logic                              fast_rx_clk,
  output logic                              gig_tx_clk,
  output logic                              gig_rx_clk
);
  import clkgen_pkg::*;

  logic             fast_active;
  logic [CNT_W-1:0] fast_half;
  logic             fast_rst;
  logic             fast_clk;
  logic [CNT_W-1:0] fast_half_r;
  logic [CNT_W-1:0] fast_half_nxt;
  logic             fast_restart;
  logic             gig_rx_active;
  logic             gig_rx_rst;
  logic             gig_rx_div;
  logic             mdc_div;
  logic             scl_div;
  logic [CNT_W-1:0] usec_half;
  logic             usec_pulse;

  // Reference cycles between microsecond ticks; a zero setting falls back to nominal
  assign usec_half = (microsecond_divider == '0) ? USEC_DIV_RST : microsecond_divider;

  // Microsecond timebase: one pulse every usec_half reference cycles
  clk_divider u_usec (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .count_en   (1'b1),
    .half_count (usec_half),
    .tick       (usec_pulse),
    .clk_out    ()
  );
  assign usec_tick = usec_pulse;

  // Management clock toggles every microsecond: 500 kHz from a nominal reference
  clk_divider u_mdc (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .count_en   (usec_pulse),
    .half_count (MDC_HALF_US),
    .tick       (),
    .clk_out    (mdc_div)
  );

  // Serial clock toggles every ten microseconds: 50 kHz from a nominal reference
  clk_divider u_scl (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .count_en   (usec_pulse),
    .half_count (SCL_HALF_US),
    .tick       (),
    .clk_out    (scl_div)
  );

  // Fast port half period by mode and speed
  always_comb begin
    fast_active = 1'b0;
    fast_half   = RMII100_HALF;
    unique case (fast_port_mode)
      FAST_NORMAL: begin
        fast_active = 1'b0;
      end
      FAST_REV_MII: begin
        fast_active = 1'b1;
        fast_half   = fast_port_speed_100 ? RMII100_HALF : RMII10_HALF;
      end
      FAST_REV_GPSI: begin
        fast_active = 1'b1;
        fast_half   = GPSI_HALF;
      end
      default: begin
        fast_active = 1'b0;
      end
    endcase
  end

  // Remembers the fast port half period last applied to the divider
  always_comb begin
    fast_half_nxt = fast_half;
  end

  // A stale count from a slower setting would otherwise delay the new rate
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fast_half_r <= RMII100_HALF;
    end else begin
      fast_half_r <= fast_half_nxt;
    end
  end

  // Restart on a new half period so the new rate starts from a known phase
  assign fast_restart = (fast_half_r != fast_half);

  // Held in reset while idle, so each entry from normal mode starts from a known phase
  assign fast_rst = sys_rst | ~fast_active | fast_restart;

  clk_divider u_fast (
    .mclk       (mclk),
    .sys_rst    (fast_rst),
    .count_en   (1'b1),
    .half_count (fast_half),
    .tick       (),
    .clk_out    (fast_clk)
  );

  // Gigabit reverse MII receive clock; divided from the 50 MHz mclk, not from gig_ref_clk
  always_comb begin
    gig_rx_active = 1'b0;
    unique case (gig_port_mode)
      GIG_OTHER:   gig_rx_active = 1'b0;
      GIG_GMII:    gig_rx_active = 1'b0;
      GIG_REV_MII: gig_rx_active = 1'b1;
      default:     gig_rx_active = 1'b0;
    endcase
  end

  assign gig_rx_rst = sys_rst | ~gig_rx_active;

  clk_divider u_gig_rx (
    .mclk       (mclk),
    .sys_rst    (gig_rx_rst),
    .count_en   (1'b1),
    .half_count (GIG_RX_HALF),
    .tick       (),
    .clk_out    (gig_rx_div)
  );

  // Output clocks straight from the divider flops
  assign mdc         = mdc_div;
  assign scl         = scl_div;
  assign fast_tx_clk = fast_clk;
  assign fast_rx_clk = fast_clk;
  assign gig_rx_clk  = gig_rx_div;

  // Forwarded gigabit reference; quiet outside GMII mode
  assign gig_tx_clk = (gig_port_mode == GIG_GMII) ? gig_ref_clk : 1'b0;

endmodule : switch_port_clock_generation

`default_nettype wire

// >>> tb/clkgen_asserts.sv
// Port assertions of the clock generator
`timescale 1ns/1ps
`default_nettype none
module clkgen_asserts import clkgen_pkg::*; (
  input wire logic             mclk,
  input wire logic             sys_rst,
  input wire logic [CNT_W-1:0] microsecond_divider,
  input wire fast_mode_t       fast_port_mode,
  input wire logic             fast_port_speed_100,
  input wire gig_mode_t        gig_port_mode,
  input wire logic             gig_ref_clk,
  input wire logic             usec_tick,
  input wire logic             mdc,
  input wire logic             scl,
  input wire logic             fast_tx_clk,
  input wire logic             fast_rx_clk,
  input wire logic             gig_tx_clk,
  input wire logic             gig_rx_clk
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Cycles since reset release, saturating, so history is never read from reset
  logic [2:0] age_r, age_nxt;
  always_comb age_nxt = sys_rst ? 3'h0 : age_r + 3'(age_r != 3'h7);
  always_ff @(posedge mclk) age_r <= age_nxt;
  property p_tick; usec_tick && microsecond_divider == 16'h0032 |-> ##50 usec_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick spacing wrong");
  property p_mdc; age_r != 3'h0 |-> $changed(mdc) == $past(usec_tick); endproperty
  a_mdc: assert property (p_mdc) else $error("mdc edge off tick");
  property p_scl; age_r != 3'h0 && $changed(scl) |-> $past(usec_tick); endproperty
  a_scl: assert property (p_scl) else $error("scl edge off tick");
  property p_f100; age_r == 3'h7 && fast_port_speed_100 && $past(fast_port_speed_100, 3)
    && fast_port_mode == FAST_REV_MII && $past(fast_port_mode, 3) == FAST_REV_MII |-> fast_tx_clk != $past(fast_tx_clk);
  endproperty
  a_f100: assert property (p_f100) else $error("fast clock not half rate");
  property p_gpsi; age_r == 3'h7 && fast_port_mode == FAST_REV_GPSI && $past(fast_port_mode, 3) == FAST_REV_GPSI
    |-> fast_tx_clk != $past(fast_tx_clk); endproperty
  a_gpsi: assert property (p_gpsi) else $error("fast clock not half rate in GPSI mode");
  property p_pair; fast_tx_clk == fast_rx_clk; endproperty
  a_pair: assert property (p_pair) else $error("fast clocks differ");
  property p_off; age_r == 3'h7 && fast_port_mode == FAST_NORMAL && $past(fast_port_mode) == FAST_NORMAL |-> !fast_tx_clk;
  endproperty
  a_off: assert property (p_off) else $error("fast clock runs in normal mode");
  property p_gtx; gig_tx_clk == (gig_ref_clk && gig_port_mode == GIG_GMII); endproperty
  a_gtx: assert property (p_gtx) else $error("gig tx clock wrong");
  property p_grx; age_r == 3'h7 && gig_port_mode == GIG_REV_MII && $past(gig_port_mode, 3) == GIG_REV_MII
    |-> gig_rx_clk != $past(gig_rx_clk); endproperty
  a_grx: assert property (p_grx) else $error("gig rx clock not half rate");
endmodule : clkgen_asserts
`default_nettype wire

// >>> tb/port_phy_model.sv
// Far-side port model: gigabit reference source and receive clock monitor
`timescale 1ns/1ps
`default_nettype none
module port_phy_model (
  output logic     gig_ref_clk,
  input wire logic fast_rx_clk,
  output int       rx_edges
);
  // 125 MHz reference, offset so its edges never meet mclk edges
  initial begin
    gig_ref_clk = 1'b0;
    #1;
    forever #4 gig_ref_clk = ~gig_ref_clk;
  end
  // Counts receive clocks taken from the switch
  initial begin
    rx_edges = 0;
    forever @(posedge fast_rx_clk) rx_edges++;
  end
endmodule : port_phy_model
`default_nettype wire

// >>> tb/switch_port_clock_generation_tb.sv
// Self-checking bench of the switch port clock generator
`timescale 1ns/1ps
`default_nettype none
module switch_port_clock_generation_tb;
  import clkgen_pkg::*;
  logic mclk = 1'b0, sys_rst, spd = 1'b1, gig_ref_clk, usec_tick, mdc, scl, ftx, frx, gtx, grx;
  logic [CNT_W-1:0] div = 16'h0032;
  fast_mode_t fm = FAST_REV_MII;
  gig_mode_t gm = GIG_REV_MII;
  int errors = 0, compares = 0, rx_edges;
  always #10 mclk = ~mclk;
  switch_port_clock_generation u_switch_port_clock_generation (.mclk, .sys_rst, .microsecond_divider(div),
    .fast_port_mode(fm), .fast_port_speed_100(spd), .gig_port_mode(gm), .gig_ref_clk, .usec_tick, .mdc, .scl,
    .fast_tx_clk(ftx), .fast_rx_clk(frx), .gig_tx_clk(gtx), .gig_rx_clk(grx));
  port_phy_model u_port_phy_model (.gig_ref_clk, .fast_rx_clk(frx), .rx_edges);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  function automatic int fast_toggles(fast_mode_t f, logic s, int w);
    return (f == FAST_REV_GPSI || f == FAST_REV_MII && s) ? w : f == FAST_REV_MII ? w / 10 : 0;
  endfunction : fast_toggles
  // Holds reset and checks the mdc, scl, fast transmit and gigabit receive clocks parked low
  task reset_chk(input int n);
    sys_rst = 1'b1;
    repeat (n) @(negedge mclk);
    check({mdc, scl, ftx, grx}, 4'h0);
    sys_rst = 1'b0;
  endtask : reset_chk
  // Applies a setting, settles, then counts output toggles over twenty microsecond tick periods
  task run(input logic [15:0] d, input fast_mode_t f, input logic s, input gig_mode_t g);
    int n, w, e0, ef;
    int t[5];
    logic [4:0] p, c;
    @(negedge mclk);
    div = d; fm = f; spd = s; gm = g;
    n = (d == 0) ? 50 : int'(d);
    w = 20 * n;
    ef = fast_toggles(f, s, w);
    repeat (150) @(negedge mclk);
    t = '{default: 0};
    e0 = rx_edges;
    p = {usec_tick, mdc, scl, ftx, grx};
    repeat (w) begin
      @(negedge mclk);
      c = {usec_tick, mdc, scl, ftx, grx};
      for (int i = 0; i < 5; i++) t[i] += int'(c[i] !== p[i]);
      p = c;
      check(gtx, gig_ref_clk && g == GIG_GMII);
    end
    check(t[4], 2 * w / n);
    check(t[3], w / n);
    check(t[2], w / n / 10);
    check(t[1], ef);
    check(rx_edges - e0, ef / 2);
    check(t[0], g == GIG_REV_MII ? w : 0);
  endtask : run
  initial begin
    void'($urandom(32'h1e5a));
    reset_chk(20);
    run(16'h0032, FAST_REV_MII, 1'b1, GIG_REV_MII);
    run(16'h0032, FAST_REV_MII, 1'b0, GIG_GMII);
    run(16'h0014, FAST_REV_GPSI, 1'b0, GIG_OTHER);
    run(16'h0000, FAST_NORMAL, 1'b1, GIG_GMII);
    reset_chk(2);
    repeat (6) run(16'($urandom_range(60, 4)), fast_mode_t'(3'h1 << $urandom_range(2)), 1'($urandom_range(1)),
      gig_mode_t'(3'h1 << $urandom_range(2)));
    finish_test();
  end
  // Cuts a hang short
  initial begin
    #1000000;
    errors++;
    finish_test();
  end
endmodule : switch_port_clock_generation_tb
bind switch_port_clock_generation clkgen_asserts u_clkgen_asserts (.mclk, .sys_rst, .microsecond_divider,
  .fast_port_mode, .fast_port_speed_100, .gig_port_mode, .gig_ref_clk, .usec_tick, .mdc, .scl, .fast_tx_clk,
  .fast_rx_clk, .gig_tx_clk, .gig_rx_clk);
`default_nettype wire
